// ===== sle_consts.svh
// Purpose: Constants for the spare lane enable and sync header configuration block
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes:   Timing-free block; only offsets, fields, reset values and encodings live here
//
// Behaviour
// - Link A has a seven-bit spare lane mask in bits 7:1.
// - Link B has an identical seven-bit spare lane mask in bits 7:1.
// - Spare serializer control clear: masked spare lanes get link clocks only.
// - Spare serializer control set: masked spare lanes also get serializers.
// - Spare lanes run at the rate and mode of link mode and test pattern.
// - Mask-only lanes with test pattern 0 or 5 send an octet ramp (pattern 4).
// - Channel power-down wins; spare lanes stay inactive on a powered-down link.
// - Serializer n is clocked only if lanes 0 to n-1 are all enabled.
// - Two-bit sync header mode acts only when link mode uses 64b/66b.
// - Mode 0 sends CRC-12, mode 2 sends FEC, modes 1 and 3 reserved.
// - Every command field of the sync word is driven as zero.
// - Both channels powered down shuts the whole serial output subsystem.
`ifndef SLE_CONSTS_SVH
`define SLE_CONSTS_SVH

// Register indices as printed, byte address is index times four
`define SLE_IDX_SPARE_A     12'h20A
`define SLE_IDX_SPARE_B     12'h20B
`define SLE_IDX_SYNC_HDR    12'h20F
`define SLE_IDX_LINK_CTRL   12'h220
`define SLE_IDX_STATUS      12'h221

// Field positions
`define SLE_SER_BIT         0
`define SLE_MASK_LSB        1
`define SLE_MASK_MSB        7
`define SLE_SYNC_HEADER_CONTENT_SELECT_MSB      1
`define SLE_CTRL_EN_BIT     0
`define SLE_CTRL_PDA_BIT    1
`define SLE_CTRL_PDB_BIT    2

// Reset values and encodings
`define SLE_RST_REG         8'h00
`define SLE_SH_CRC12        2'h0
`define SLE_SH_FEC          2'h2
`define SLE_TEST_NONE       4'h0
`define SLE_TEST_RAMP       4'h4
`define SLE_TEST_ALT        4'h5

// AXI responses
`define SLE_RESP_OKAY       2'h0
`define SLE_RESP_SLVERR     2'h2

`endif

// ===== sle_lane_rx.sv
// Purpose: Far-side lane receiver model
// Assumes: A lane delivers data only while clocked and serialized
// Notes:   Registers the live lane set once per clock
`timescale 1ns/1ns
`default_nettype none
module sle_lane_rx (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Lane drive from the block
  input  wire sle_pkg::sle_lanes_t lanesA,
  input  wire sle_pkg::sle_lanes_t lanesB,
  // Lanes seen carrying data
  output var  logic [7:0]          rxA,
  output var  logic [7:0]          rxB
);
  import sle_pkg::*;
  // A serializer without its link clock sends nothing, so both must be on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxA <= 8'h00;
      rxB <= 8'h00;
    end else begin
      rxA <= lanesA.serOn & lanesA.laneClk;
      rxB <= lanesB.serOn & lanesB.laneClk;
    end
  end
endmodule
`default_nettype wire

// ===== sle_pkg.sv
// Purpose: Types for the spare lane enable and sync header configuration block
// Assumes: Eight lanes per link
// Notes:   Constants live in sle_consts.svh
`default_nettype none
package sle_pkg;
  typedef enum logic [1:0] {SLE_SH_CRC, SLE_SH_FECW, SLE_SH_OFF} sle_sh_kind_t;

  // Per-link lane drive
  typedef struct packed {
    logic [7:0] laneClk;
    logic [7:0] serOn;
    logic [7:0] rampSel;
  } sle_lanes_t;

  // Link layer status from the transmitter datapath
  typedef struct packed {
    logic [7:0] modeLanesA;
    logic [7:0] modeLanesB;
    logic       mode64b66b;
    logic [3:0] testPattern;
  } sle_mode_t;

  typedef enum logic [1:0] {SLE_WR_IDLE, SLE_WR_RESP} sle_wr_st_t;
endpackage
`default_nettype wire

// ===== sle_spare_lane_cfg.sv
// Purpose: Spare lane masks, spare serializer controls and sync header selection
// Assumes: AXI4-Lite slave, single clock, link mode decoded elsewhere
// Notes:   Writes to locked registers while the link runs are refused with SLVERR
`timescale 1ns/1ns
`default_nettype none
`include "sle_consts.svh"

module sle_spare_lane_cfg (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // AXI4-Lite write
  input  wire logic [13:0]          awaddr,
  input  wire logic                 awvalid,
  output var  logic                 awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output var  logic                 wready,
  output var  logic [1:0]           bresp,
  output var  logic                 bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read
  input  wire logic [13:0]          araddr,
  input  wire logic                 arvalid,
  output var  logic                 arready,
  output var  logic [31:0]          rdata,
  output var  logic [1:0]           rresp,
  output var  logic                 rvalid,
  input  wire logic                 rready,
  // Link mode decode from the transmitter
  input  wire sle_pkg::sle_mode_t   modeIn,
  // Lane drive
  output var  sle_pkg::sle_lanes_t  lanesA,
  output var  sle_pkg::sle_lanes_t  lanesB,
  output var  logic                 subsysOn,
  output var  logic [1:0]           syncHdrKind,
  output var  logic [3:0]           syncCmd
);
  import sle_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  spareA;
  logic [7:0]  spareB;
  logic [1:0]  sync_header_content_select;
  logic        linkEn;
  logic [1:0]  chanPd;
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awIdx;
  logic [31:0] wDat;
  logic [3:0]  wStb;

  // Word index from a byte address
  function automatic logic [11:0] idxOf(input logic [13:0] a);
    idxOf = a[13:2];
  endfunction

  // Lane n clocked for a serializer only when all lower lanes are on
  function automatic logic [7:0] chainOk(input logic [7:0] on);
    logic [7:0] ok;
    ok = 8'h00;
    ok[0] = on[0];
    for (int n = 1; n < 8; n++) begin
      ok[n] = on[n] & ok[n - 1];
    end
    chainOk = ok;
  endfunction

  // One link's lane drive
  function automatic sle_lanes_t laneDrive(input logic [7:0] spare, input logic [7:0] modeL,
                                           input logic pd, input logic [3:0] tp,
                                           input logic up);
    sle_lanes_t r;
    logic [7:0] extra;
    logic [7:0] clkOn;
    logic [7:0] serReq;
    logic       rampTp;
    r      = '0;
    extra  = {spare[`SLE_MASK_MSB:`SLE_MASK_LSB], 1'b0} & ~modeL;
    rampTp = (tp == `SLE_TEST_NONE) || (tp == `SLE_TEST_ALT);
    clkOn  = modeL | extra;
    serReq = spare[`SLE_SER_BIT] ? clkOn : modeL;
    if (up && !pd) begin
      r.laneClk = clkOn;
      r.serOn   = serReq & chainOk(clkOn);
      r.rampSel = rampTp ? extra : 8'h00;
    end
    laneDrive = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  wire        wrFire    = awHeld && wHeld && !bvalid;
  wire        wrLocked  = linkEn;
  wire        hitA      = (awIdx == `SLE_IDX_SPARE_A);
  wire        hitB      = (awIdx == `SLE_IDX_SPARE_B);
  wire        hitSh     = (awIdx == `SLE_IDX_SYNC_HDR);
  wire        hitCtrl   = (awIdx == `SLE_IDX_LINK_CTRL);
  wire        hitStat   = (awIdx == `SLE_IDX_STATUS);
  wire        wrMapped  = hitA || hitB || hitSh || hitCtrl || hitStat;
  wire        wrCfgOk   = wrFire && wStb[0] && !wrLocked;
  wire        wrCtrlOk  = wrFire && wStb[0] && hitCtrl;
  wire        wrBad     = !wrMapped || (wrLocked && (hitA || hitB || hitSh));
  wire [7:0]  wByte     = wDat[7:0];

  // Read decode
  wire [11:0] arIdx     = idxOf(araddr);
  wire        rdMapped  = (arIdx == `SLE_IDX_SPARE_A) || (arIdx == `SLE_IDX_SPARE_B) ||
                          (arIdx == `SLE_IDX_SYNC_HDR) || (arIdx == `SLE_IDX_LINK_CTRL) ||
                          (arIdx == `SLE_IDX_STATUS);
  wire [31:0] rdWord    = (arIdx == `SLE_IDX_SPARE_A)   ? {24'h000000, spareA} :
                          (arIdx == `SLE_IDX_SPARE_B)   ? {24'h000000, spareB} :
                          (arIdx == `SLE_IDX_SYNC_HDR)  ? {30'h00000000, sync_header_content_select} :
                          (arIdx == `SLE_IDX_LINK_CTRL) ? {29'h00000000, chanPd, linkEn} :
                          (arIdx == `SLE_IDX_STATUS)    ? {8'h00, lanesB.serOn, lanesA.serOn,
                                                           lanesA.laneClk} :
                          32'h00000000;

  // Lane and sync header next values
  wire        bothPd    = &chanPd;
  wire        nextOn    = linkEn && !bothPd;
  wire sle_lanes_t next_lanesA = laneDrive(spareA, modeIn.modeLanesA, chanPd[0],
                                           modeIn.testPattern, nextOn);
  wire sle_lanes_t next_lanesB = laneDrive(spareB, modeIn.modeLanesB, chanPd[1],
                                           modeIn.testPattern, nextOn);
  wire [1:0]  next_kind = !modeIn.mode64b66b      ? SLE_SH_OFF :
                          (sync_header_content_select == `SLE_SH_FEC)  ? SLE_SH_FECW :
                          SLE_SH_CRC;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture, address and data taken in either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awIdx  <= 12'h000;
      wDat   <= 32'h00000000;
      wStb   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awIdx  <= idxOf(awaddr);
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDat  <= wdata;
        wStb  <= wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Ready flags; one write outstanding at a time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !awHeld && !(awvalid && awready) && !bvalid && !wrFire;
      wready  <= !wHeld && !(wvalid && wready) && !bvalid && !wrFire;
    end
  end

  // Write response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= `SLE_RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= wrBad ? `SLE_RESP_SLVERR : `SLE_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration registers, frozen while the link runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spareA <= `SLE_RST_REG;
      spareB <= `SLE_RST_REG;
      sync_header_content_select <= `SLE_SH_CRC12;
    end else if (wrCfgOk) begin
      if (hitA) spareA <= wByte;
      if (hitB) spareB <= wByte;
      if (hitSh) sync_header_content_select <= wByte[`SLE_SYNC_HEADER_CONTENT_SELECT_MSB:0];
    end
  end

  // Link enable and channel power down
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linkEn <= 1'b0;
      chanPd <= 2'b00;
    end else if (wrCtrlOk) begin
      linkEn <= wByte[`SLE_CTRL_EN_BIT];
      chanPd <= wByte[`SLE_CTRL_PDB_BIT:`SLE_CTRL_PDA_BIT];
    end
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `SLE_RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdMapped ? rdWord : 32'h00000000;
        rresp  <= rdMapped ? `SLE_RESP_OKAY : `SLE_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane drive outputs, registered so no glitch reaches the serializers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lanesA      <= '0;
      lanesB      <= '0;
      subsysOn    <= 1'b0;
      syncHdrKind <= SLE_SH_OFF;
      syncCmd     <= 4'h0;
    end else begin
      lanesA      <= next_lanesA;
      lanesB      <= next_lanesB;
      subsysOn    <= nextOn;
      syncHdrKind <= next_kind;
      syncCmd     <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Bus steps; each sequence names one stage of a write or read transfer
  sequence s_wrTaken;
    wrFire;
  endsequence

  sequence s_cfgWrite;
    wrFire && wStb[0] && hitA;
  endsequence

  sequence s_lockedWrite;
    wrFire && linkEn && (hitA || hitB || hitSh);
  endsequence

  sequence s_rdTaken;
    arvalid && arready;
  endsequence

  sequence s_bHeld;
    bvalid && !bready;
  endsequence

  sequence s_rHeld;
    rvalid && !rready;
  endsequence

  // Lane steps; a spare lane only counts once its link is powered
  sequence s_linkAUp;
    nextOn && !chanPd[0];
  endsequence

  sequence s_linkBUp;
    nextOn && !chanPd[1];
  endsequence

  // Register storage and the run-time lock
  a_spare_a_store: assert property (@(posedge clk) disable iff (!arst_n)
    (s_cfgWrite and !linkEn) |=> spareA == $past(wByte))
    else $error("spare mask A not stored");
  a_sh_store: assert property (@(posedge clk) disable iff (!arst_n)
    (s_wrTaken and (wStb[0] && hitSh && !linkEn)) |=> sync_header_content_select == $past(wByte[1:0]))
    else $error("sync header mode not stored");
  a_locked_cfg: assert property (@(posedge clk) disable iff (!arst_n)
    linkEn |=> $stable(spareA) && $stable(spareB) && $stable(sync_header_content_select))
    else $error("config changed while link enabled");
  a_locked_resp: assert property (@(posedge clk) disable iff (!arst_n)
    s_lockedWrite |=> bvalid && bresp == `SLE_RESP_SLVERR)
    else $error("locked write not refused");

  // Handshakes; a held answer must not move until the master takes it
  a_b_answer: assert property (@(posedge clk) disable iff (!arst_n)
    s_wrTaken |=> bvalid)
    else $error("write response missing");
  a_b_stands: assert property (@(posedge clk) disable iff (!arst_n)
    s_bHeld |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_r_answer: assert property (@(posedge clk) disable iff (!arst_n)
    s_rdTaken |=> rvalid)
    else $error("read answer missing");
  a_r_stands: assert property (@(posedge clk) disable iff (!arst_n)
    s_rHeld |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped before taken");
  a_one_write: assert property (@(posedge clk) disable iff (!arst_n)
    bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_one_read: assert property (@(posedge clk) disable iff (!arst_n)
    rvalid |-> !arready)
    else $error("read taken while answer pending");

  // Lane drive; outputs follow the settings one edge later
  a_spare_b_lane: assert property (@(posedge clk) disable iff (!arst_n)
    (s_linkBUp and spareB[3]) |=> lanesB.laneClk[3])
    else $error("spare lane B3 clock missing");
  a_ser_off: assert property (@(posedge clk) disable iff (!arst_n)
    !spareA[0] |=> (lanesA.serOn & ~$past(modeIn.modeLanesA)) == 8'h00)
    else $error("spare serializer on without control");
  a_ser_on: assert property (@(posedge clk) disable iff (!arst_n)
    (s_linkAUp and (spareA[0] && spareA[1] && modeIn.modeLanesA[0])) |=> lanesA.serOn[1])
    else $error("spare serializer A1 not on");
  a_ser_chain: assert property (@(posedge clk) disable iff (!arst_n)
    lanesA.serOn[5] |-> &lanesA.laneClk[4:0])
    else $error("serializer clocked without lower lanes");
  a_pd_wins: assert property (@(posedge clk) disable iff (!arst_n)
    chanPd[0] |=> lanesA.laneClk == 8'h00)
    else $error("powered-down link has active lanes");
  a_ramp_lane: assert property (@(posedge clk) disable iff (!arst_n)
    (s_linkAUp and (spareA[2] && !modeIn.modeLanesA[2] &&
                    modeIn.testPattern == `SLE_TEST_ALT)) |=> lanesA.rampSel[2])
    else $error("mask-only lane A2 not ramped");
  a_mode_no_ramp: assert property (@(posedge clk) disable iff (!arst_n)
    modeIn.modeLanesA[1] |=> !lanesA.rampSel[1])
    else $error("mode lane A1 switched to ramp");
  a_rate_follow: assert property (@(posedge clk) disable iff (!arst_n)
    s_linkAUp |=> lanesA.laneClk[0] == $past(modeIn.modeLanesA[0]))
    else $error("lane A0 clock not following link mode");
  a_link_off: assert property (@(posedge clk) disable iff (!arst_n)
    !linkEn |=> !subsysOn && lanesA.laneClk == 8'h00 && lanesB.laneClk == 8'h00)
    else $error("lanes active with serial link disabled");
  a_both_pd: assert property (@(posedge clk) disable iff (!arst_n)
    bothPd |=> !subsysOn && lanesB.laneClk == 8'h00)
    else $error("subsystem on with both channels down");

  // Sync header content
  a_no_64b_hdr: assert property (@(posedge clk) disable iff (!arst_n)
    !modeIn.mode64b66b |=> syncHdrKind == SLE_SH_OFF)
    else $error("sync header active outside 64b/66b");
  a_sh_kind: assert property (@(posedge clk) disable iff (!arst_n)
    modeIn.mode64b66b && sync_header_content_select == `SLE_SH_FEC |=> syncHdrKind == SLE_SH_FECW)
    else $error("FEC sync header not selected");
  a_cmd_idle: assert property (@(posedge clk) disable iff (!arst_n)
    syncCmd == 4'h0)
    else $error("sync command field not idle");
endmodule

`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the spare lane configuration block
// Assumes: Byte address is the register index times four
// Notes:   Fixed-seed shift register picks settings; corner cases lead
`timescale 1ns/1ns
`default_nettype none
`include "sle_consts.svh"
module tb;
  import sle_pkg::*;
  localparam logic [13:0] addrA    = {`SLE_IDX_SPARE_A, 2'b00};
  localparam logic [13:0] addrB    = {`SLE_IDX_SPARE_B, 2'b00};
  localparam logic [13:0] addrSh   = {`SLE_IDX_SYNC_HDR, 2'b00};
  localparam logic [13:0] addrCtl  = {`SLE_IDX_LINK_CTRL, 2'b00};
  localparam logic [13:0] addrStat = {`SLE_IDX_STATUS, 2'b00};
  logic        clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, subsysOn;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb, syncCmd;
  logic [1:0]  bresp, rresp, syncHdrKind;
  logic [7:0]  rxA, rxB;
  sle_mode_t   modeIn;
  sle_lanes_t  lanesA, lanesB;
  int          n_fail, total_checks;
  logic [3:0]  tps [4] = '{`SLE_TEST_NONE, `SLE_TEST_ALT, `SLE_TEST_RAMP, 4'h1};
  logic [31:0] corner [3] = '{32'h0102ABFF, 32'h03600FFF, 32'h0693FE55};
  //////////////////////////////////////////////////////////////////////
  sle_spare_lane_cfg dut (.clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .modeIn, .lanesA, .lanesB, .subsysOn, .syncHdrKind, .syncCmd);
  sle_lane_rx rx (.clk, .arst_n, .lanesA, .lanesB, .rxA, .rxB);
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  // Shift register for repeatable random settings
  function automatic logic [31:0] nextRand(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected lane drive; control bit 0 clear leaves extras silent, the chain test silences lanes above a gap
  function automatic sle_lanes_t expL(logic [7:0] r, logic [7:0] m, logic [3:0] tp, logic pd);
    sle_lanes_t e;
    logic [7:0] x, low;
    x = {r[7:1], 1'b0} & ~m;
    e.laneClk = pd ? 8'h00 : (m | x);
    e.rampSel = (tp == `SLE_TEST_NONE || tp == `SLE_TEST_ALT) ? (x & e.laneClk) : 8'h00;
    for (int n = 0; n < 8; n++) begin
      low = 8'((9'h001 << n) - 9'h001);
      e.serOn[n] = (m[n] | (r[0] & x[n])) & !pd & ((e.laneClk & low) == low);
    end
    return e;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Write: both channels offered together, each dropped once taken
  task automatic axWr(logic [13:0] a, logic [31:0] v, logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 99 && (awvalid || wvalid || !bvalid); n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 99) begin
      n_fail++;
      results();
    end
  endtask
  task automatic axRd(logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 99 && (arvalid || !rvalid); n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 99) begin
      n_fail++;
      results();
    end
  endtask
  // One setting: program with the link off, run it, then try a locked write
  task automatic trial(logic [31:0] x);
    logic [31:0] d;
    logic [1:0]  r, pd;
    logic [7:0]  mm;
    logic [3:0]  tp;
    sle_lanes_t  ea, eb;
    mm = 8'((9'h001 << (x[21:18] % 9)) - 9'h001);
    tp = tps[x[23:22]];
    pd = x[26:25];
    axWr(addrCtl, 32'h0, 4'hF, r);
    axWr(addrA, 32'(x[7:0]), 4'hF, r);
    chk("wrResp", 32'(r), 32'(`SLE_RESP_OKAY));
    axWr(addrB, 32'(x[15:8]), 4'hF, r);
    axWr(addrSh, 32'(x[17:16]), 4'hF, r);
    axRd(addrA, d, r);
    chk("spareA", d, 32'(x[7:0]));
    axRd(addrB, d, r);
    chk("spareB", d, 32'(x[15:8]));
    axRd(addrSh, d, r);
    chk("syncMode", d, 32'(x[17:16]));
    modeIn <= {mm, mm >> 1, x[24], tp};
    axWr(addrCtl, {29'h0, pd, 1'b1}, 4'hF, r);
    repeat (3) @(posedge clk);
    ea = expL(x[7:0], mm, tp, pd[0]);
    eb = expL(x[15:8], mm >> 1, tp, pd[1]);
    chk("lanesA", 32'(lanesA), 32'(ea));
    chk("lanesB", 32'(lanesB), 32'(eb));
    chk("rxLanes", {16'h0, rxB, rxA}, {16'h0, eb.serOn, ea.serOn});
    chk("subsys", 32'(subsysOn), 32'(~&pd));
    chk("hdrKind", 32'(syncHdrKind), 32'(!x[24] ? SLE_SH_OFF :
      (x[17:16] == `SLE_SH_FEC) ? SLE_SH_FECW : SLE_SH_CRC));
    chk("syncCmd", 32'(syncCmd), 32'h0);
    axRd(addrStat, d, r);
    chk("status", d, {8'h00, eb.serOn, ea.serOn, ea.laneClk});
    axWr(addrA, 32'(~x[7:0]), 4'hF, r);
    chk("lockResp", 32'(r), 32'(`SLE_RESP_SLVERR));
    axRd(addrA, d, r);
    chk("lockKeep", d, 32'(x[7:0]));
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    n_fail = 0;
    total_checks = 0;
    seed = 32'h0001031C;
    arst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb, modeIn} = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    axRd(addrA, d, r);
    chk("rstA", d, 32'h0);
    axRd(addrB, d, r);
    chk("rstB", d, 32'h0);
    axRd(addrSh, d, r);
    chk("rstSync", d, 32'h0);
    axRd(14'h0840, d, r);
    chk("unmapRd", {d[29:0], r}, 32'(`SLE_RESP_SLVERR));
    axWr(14'h0840, 32'hFF, 4'hF, r);
    chk("unmapWr", 32'(r), 32'(`SLE_RESP_SLVERR));
    axWr(addrA, 32'hFF, 4'h0, r);
    axRd(addrA, d, r);
    chk("noStrobe", d, 32'h0);
    for (int i = 0; i < 16; i++) begin
      seed = nextRand(seed);
      trial(i < 3 ? corner[i] : seed);
    end
    results();
  end
endmodule
`default_nettype wire
